// ===== hdl/stop_mode_power_sequencer.sv
/*
  Stop-mode sequencer: decides stop type at the core stop strobe, gates
  clocks and regulators, holds pin latches and reports the wake vector.
  Assumes one 125 MHz bus clock, synchronous inputs and a register port
  driven by a master that never issues read and write together.
*/
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module stop_mode_power_sequencer
    import stop_seq_pkg::*;
#(
    parameter int WAKE_TICK = `WAKE_TICK_CYC  // bus cycles per 1 kHz tick
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [15:0] regRdData,
    // core and wake pins
    input  wire logic        stopStrobe,
    input  wire logic        resetPin_n,
    input  wire logic        irqPin_n,
    input  wire wake_req_t   wakeReq,
    input  wire logic        bgCommand,
    input  wire logic        memStatusCmd,
    // outputs to the system
    output power_ctl_t       powerCtl,
    output logic             illegalOpReset,
    output logic             partialWakeReset,
    output logic             wakeValid,
    output wake_src_t        wakeSource,
    output logic             stopStatusErr,
    output logic             enterBackground
);

    initial begin
        if (WAKE_TICK < 2) begin
            $error("WAKE_TICK must be at least 2");
        end
    end

    logic [15:0] ctrl_r;       // software control bits
    mode_t       mode_r;       // current stop mode
    logic        ppdFlag_r;    // set after partial wake
    logic        latched_r;    // pin latches closed
    wake_src_t   src_r;        // last wake cause
    logic [31:0] tickCnt_r;    // 1 kHz divider
    logic        tick;         // one periodic wake tick
    logic        wsel0;        // periodic wake select is zero
    logic        stopReq;      // stop strobe while running, stop enabled or not
    logic        wakeFull;     // wake from full retention
    logic        wakePart;     // wake from partial
    wake_src_t   srcNxt;       // cause chosen this cycle

    assign wsel0   = (ctrl_r[`CTL_WSEL_HI:`CTL_WSEL_LO] == 3'h0);
    assign stopReq = stopStrobe && (mode_r == MODE_RUN);

    // periodic source runs in both stops unless select is zero
    always_ff @(posedge sys_clk) begin
        if (reset || wsel0 || mode_r == MODE_RUN) begin
            tickCnt_r <= 32'h0;
        end else if (tickCnt_r == 32'(WAKE_TICK - 1)) begin
            tickCnt_r <= 32'h0;
        end else begin
            tickCnt_r <= tickCnt_r + 32'h1;
        end
    end
    assign tick = !wsel0 && mode_r != MODE_RUN && tickCnt_r == 32'(WAKE_TICK - 1);

    // wake cause in priority order; reset pin wins
    always_comb begin
        srcNxt = SRC_NONE;
        if (mode_r == MODE_FULL) begin
            if (!resetPin_n)                                  srcNxt = SRC_RESET;
            else if (tick)                                    srcNxt = SRC_PERIOD;
            else if (wakeReq.lowvolt_detector)                             srcNxt = SRC_LVD;
            else if (wakeReq.adc)                             srcNxt = SRC_ADC;
            else if (wakeReq.irq)                             srcNxt = SRC_IRQ;
            else if (wakeReq.keypad)                          srcNxt = SRC_KEYPAD;
            else if (wakeReq.serial)                          srcNxt = SRC_SERIAL;
            else if (bgCommand && ctrl_r[`CTL_DBG_EN])        srcNxt = SRC_DEBUG;
        end else if (mode_r == MODE_PART) begin
            // irq pin is low-active here whatever its prior setup
            if (!resetPin_n)                                  srcNxt = SRC_RESET;
            else if (!irqPin_n)                               srcNxt = SRC_IRQ;
            else if (tick)                                    srcNxt = SRC_PERIOD;
        end
    end
    assign wakeFull = (mode_r == MODE_FULL) && (srcNxt != SRC_NONE);
    assign wakePart = (mode_r == MODE_PART) && (srcNxt != SRC_NONE);

    // mode chosen once at the strobe and kept until wake
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mode_r <= MODE_RUN;
        end else if (stopReq && ctrl_r[`CTL_STOP_EN]) begin
            if (ctrl_r[`CTL_PPD_SEL] && !ctrl_r[`CTL_DBG_EN] &&
                !(ctrl_r[`CTL_LVD_EN] && ctrl_r[`CTL_LVD_STOP])) begin
                mode_r <= MODE_PART;
            end else begin
                mode_r <= MODE_FULL;
            end
        end else if (wakeFull || wakePart) begin
            mode_r <= MODE_RUN;
        end
    end

    // wake cause register and one-cycle wake pulse
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            src_r     <= SRC_NONE;
            wakeValid <= 1'b0;
        end else begin
            wakeValid <= wakeFull || wakePart;
            if (wakeFull || wakePart) begin
                // partial wake always takes the reset path
                src_r <= wakePart ? SRC_RESET : srcNxt;
            end
        end
    end
    assign wakeSource = src_r;

    // stop strobe with stop disabled is an illegal opcode
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            illegalOpReset <= 1'b0;
        end else begin
            illegalOpReset <= stopReq && !ctrl_r[`CTL_STOP_EN];
        end
    end

    // partial wake behaves like power-on reset of all logic but the pin latch, partial flag and wake cause
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            partialWakeReset <= 1'b0;
        end else begin
            partialWakeReset <= wakePart;
        end
    end

    // debug side effects while stopped
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stopStatusErr   <= 1'b0;
            enterBackground <= 1'b0;
        end else begin
            stopStatusErr   <= memStatusCmd && (mode_r != MODE_RUN);
            enterBackground <= wakeFull && srcNxt == SRC_DEBUG;
        end
    end

    // pin latch and partial flag; partial stop entry sets the latch, the partial wake sets the flag, ack clears, set wins
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            latched_r <= 1'b0;
            ppdFlag_r <= 1'b0;
        end else begin
            if (stopReq && ctrl_r[`CTL_STOP_EN] && mode_r == MODE_RUN &&
                ctrl_r[`CTL_PPD_SEL] && !ctrl_r[`CTL_DBG_EN] &&
                !(ctrl_r[`CTL_LVD_EN] && ctrl_r[`CTL_LVD_STOP])) begin
                latched_r <= 1'b1;
            end else if (regWrite && regAddr == `OFS_STATUS &&
                         regWrData[`STS_ACK_BIT] && mode_r == MODE_RUN) begin
                latched_r <= 1'b0;
            end
            if (wakePart) begin
                ppdFlag_r <= 1'b1;
            end else if (regWrite && regAddr == `OFS_STATUS &&
                         regWrData[`STS_ACK_BIT]) begin
                ppdFlag_r <= 1'b0;
            end
        end
    end

    // control register; partial wake returns it to reset value
    // writes are refused while stopped so the gating chosen at the strobe holds
    always_ff @(posedge sys_clk) begin
        if (reset || wakePart) begin
            ctrl_r <= `CTL_RESET_VAL;
        end else if (regWrite && regAddr == `OFS_CTRL && mode_r == MODE_RUN) begin
            ctrl_r <= regWrData;
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            regRdData <= 16'h0000;
        end else if (regRead) begin
            case (regAddr)
                `OFS_CTRL:   regRdData <= ctrl_r;
                `OFS_STATUS: regRdData <= {8'h00, src_r, latched_r,
                                           mode_r == MODE_PART,
                                           mode_r == MODE_FULL, ppdFlag_r};
                default:     regRdData <= 16'h0000;
            endcase
        end else begin
            regRdData <= 16'h0000;
        end
    end

    // gating outputs; state in full stop is kept simply by holding clocks
    always_comb begin
        powerCtl.periphClkOn   = (mode_r == MODE_RUN);
        powerCtl.debugClkOn    = (mode_r == MODE_RUN) || ctrl_r[`CTL_DBG_EN];
        powerCtl.clkGenOn      = (mode_r == MODE_RUN) ||
                                 (mode_r == MODE_FULL && ctrl_r[`CTL_DBG_EN]);
        powerCtl.oscOn         = (mode_r == MODE_RUN) ||
                                 (mode_r == MODE_FULL &&
                                  (ctrl_r[`CTL_OSC_STBY] || ctrl_r[`CTL_DBG_EN]));
        powerCtl.regulatorFull = (mode_r == MODE_RUN) || ctrl_r[`CTL_DBG_EN] ||
                                 (ctrl_r[`CTL_LVD_EN] && ctrl_r[`CTL_LVD_STOP]);
        powerCtl.adcActive     = (mode_r == MODE_RUN) ||
                                 (mode_r == MODE_FULL && ctrl_r[`CTL_ADC_ACLK]);
        powerCtl.pinLatch      = latched_r;
        powerCtl.keypadArmed   = (mode_r != MODE_PART);
    end

    // checks
    chk_illegal_stop: assert property (@(posedge sys_clk) disable iff (reset)
        stopReq && !ctrl_r[`CTL_STOP_EN] |=> illegalOpReset && mode_r == MODE_RUN)
        else $error("stop while disabled not refused");
    chk_part_entry: assert property (@(posedge sys_clk) disable iff (reset)
        stopReq && ctrl_r[`CTL_STOP_EN] && ctrl_r[`CTL_PPD_SEL] &&
        !ctrl_r[`CTL_DBG_EN] && !(ctrl_r[`CTL_LVD_EN] && ctrl_r[`CTL_LVD_STOP])
        |=> mode_r == MODE_PART && latched_r)
        else $error("partial stop not entered");
    chk_full_entry: assert property (@(posedge sys_clk) disable iff (reset)
        stopReq && ctrl_r[`CTL_STOP_EN] && !ctrl_r[`CTL_PPD_SEL] |=> mode_r == MODE_FULL)
        else $error("full stop not entered");
    chk_debug_force: assert property (@(posedge sys_clk) disable iff (reset)
        stopReq && ctrl_r[`CTL_STOP_EN] && ctrl_r[`CTL_DBG_EN] |=> mode_r == MODE_FULL)
        else $error("debug did not force full stop");
    chk_lvd_force: assert property (@(posedge sys_clk) disable iff (reset)
        stopReq && ctrl_r[`CTL_STOP_EN] && ctrl_r[`CTL_LVD_EN] && ctrl_r[`CTL_LVD_STOP]
        |=> mode_r == MODE_FULL && powerCtl.regulatorFull)
        else $error("lowvolt did not force full stop");
    chk_periph_clk: assert property (@(posedge sys_clk) disable iff (reset)
        mode_r != MODE_RUN |-> !powerCtl.periphClkOn)
        else $error("peripheral clock runs in stop");
    chk_osc_part: assert property (@(posedge sys_clk) disable iff (reset)
        mode_r == MODE_PART |-> !powerCtl.oscOn && !powerCtl.clkGenOn)
        else $error("oscillator on in partial stop");
    chk_flag_hold: assert property (@(posedge sys_clk) disable iff (reset)
        wakePart |=> ppdFlag_r && src_r == SRC_RESET && partialWakeReset)
        else $error("partial wake flag missing");
    chk_status_err: assert property (@(posedge sys_clk) disable iff (reset)
        memStatusCmd && mode_r != MODE_RUN |=> stopStatusErr)
        else $error("status error not reported");
    chk_wake_reset: assert property (@(posedge sys_clk) disable iff (reset)
        mode_r == MODE_FULL && !resetPin_n |=> mode_r == MODE_RUN && src_r == SRC_RESET)
        else $error("reset pin did not wake");
    chk_wsel_zero: assert property (@(posedge sys_clk) disable iff (reset)
        wsel0 |-> !tick)
        else $error("periodic wake with select zero");

    cov_part_cycle: cover property (@(posedge sys_clk) disable iff (reset)
        mode_r == MODE_PART ##[1:1000] mode_r == MODE_RUN);
    cov_full_cycle: cover property (@(posedge sys_clk) disable iff (reset)
        mode_r == MODE_FULL ##[1:1000] wakeValid);
    cov_debug_wake: cover property (@(posedge sys_clk) disable iff (reset)
        enterBackground);
    cov_illegal: cover property (@(posedge sys_clk) disable iff (reset)
        illegalOpReset);

endmodule // stop_mode_power_sequencer
`default_nettype wire

// ===== pkg/stop_seq_pkg.sv
/*
  Types for the stop-mode power sequencer.
  Assumes the constants header sits next to it on the include path.
*/
`default_nettype none
package stop_seq_pkg;
    `include "stop_seq_regs.svh"

    // sequencer modes
    typedef enum logic [1:0] {
        MODE_RUN  = 2'b00,
        MODE_FULL = 2'b01,
        MODE_PART = 2'b10
    } mode_t;

    // wake cause, drives vector choice
    typedef enum logic [3:0] {
        SRC_NONE   = 4'h0,
        SRC_RESET  = 4'h1,
        SRC_PERIOD = 4'h2,
        SRC_LVD    = 4'h3,
        SRC_ADC    = 4'h4,
        SRC_IRQ    = 4'h5,
        SRC_KEYPAD = 4'h6,
        SRC_SERIAL = 4'h7,
        SRC_DEBUG  = 4'h8
    } wake_src_t;

    // interrupt requests from wake sources
    typedef struct packed {
        logic lowvolt_detector;
        logic adc;
        logic irq;
        logic keypad;
        logic serial;
    } wake_req_t;

    // power and clock gating outputs
    typedef struct packed {
        logic periphClkOn;
        logic debugClkOn;
        logic oscOn;
        logic clkGenOn;
        logic regulatorFull;
        logic adcActive;
        logic pinLatch;
        logic keypadArmed;
    } power_ctl_t;
endpackage
`default_nettype wire

// ===== pkg/stop_seq_regs.svh
/*
  Constants for the stop-mode power sequencer: register offsets, field
  positions, reset values and timing counts.
  Assumes it is included by bare name from the package and the bench.
*/
// Notes on behaviour
// - software restores port values before latch ack
// - unconfigured peripheral pins follow port control
// - stop with select 0 enters full retention
// - full retention halts clocks, standby regulators
// - full retention keeps all state, pins unlatched
// - full retention wakes on reset or interrupts
// - reset wake fetches reset, interrupt fetches vector
// - periodic wake select zero disables source
// - debug enable keeps debug clock and regulator
// - debug enable turns partial into full retention
// - memory status commands error while stopped
// - background command wakes into debug mode
// - lowvolt stop enable keeps regulator active
// - lowvolt in stop forces full retention
// - peripheral clocks stop in every stop
// - oscillator runs only in full retention standby
// - partial wake resets all, keeps latches
// - converter standby unless async clock enabled
// - keypad wakes full retention only
// - partial stop latches pins before entry
// - select 1 without lowvolt enters partial
// - stop while disabled forces illegal opcode reset
// - partial flag held until latch ack written
// - partial wakes on reset, irq low, periodic
`ifndef STOP_SEQ_REGS_SVH
`define STOP_SEQ_REGS_SVH

// register offsets
`define OFS_CTRL        4'h0
`define OFS_STATUS      4'h1
`define OFS_WAKE        4'h2

// control register fields
`define CTL_STOP_EN     0
`define CTL_PPD_SEL     1
`define CTL_DBG_EN      2
`define CTL_LVD_EN      3
`define CTL_LVD_STOP    4
`define CTL_OSC_STBY    5
`define CTL_ADC_ACLK    6
`define CTL_WSEL_LO     8
`define CTL_WSEL_HI     10
`define CTL_RESET_VAL   16'h0000

// status register fields
`define STS_PPD_FLAG    0
`define STS_FULL_STOP   1
`define STS_PART_STOP   2
`define STS_LATCHED     3
`define STS_SRC_LO      4
`define STS_SRC_HI      7

// write-one latch release acknowledge bit in the status register
`define STS_ACK_BIT     8

// periodic wake timing
`define BUS_CLK_KHZ     125000
`define WAKE_SRC_KHZ    1
`define WAKE_TICK_CYC   (`BUS_CLK_KHZ / `WAKE_SRC_KHZ)

`endif

// ===== testbench/tb_top.sv
/*
  Self-checking bench for the stop sequencer: register port, stop entry,
  clock and regulator gating, pin latching, every full-stop wake path and the reset and irq partial wakes.
  Assumes the package, the design and the wake model compile before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stop_seq_regs.svh"
module tb_top;
    import stop_seq_pkg::*;
    localparam int TICK = 8;  // short periodic wake keeps the run brief
    logic        sys_clk = 1'b0, reset = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic        regWrite = 1'b0, regRead = 1'b0, stopStrobe = 1'b0, memStatusCmd = 1'b0;
    wake_src_t   fire = SRC_NONE;  // command to the wake model
    logic [1:0]  lag = 2'h0;
    logic        resetPin_n, irqPin_n, bgCommand, illegalOpReset, partialWakeReset;
    logic        wakeValid, stopStatusErr, enterBackground, rdPend = 1'b0, part;
    logic [15:0] regRdData, c;
    wake_req_t   wakeReq;
    power_ctl_t  powerCtl;
    wake_src_t   wakeSource;
    logic [15:0] expRd[$];   // notes for read data
    wake_src_t   expWake[$]; // notes for wake causes
    int failures = 0, total_checks = 0, wakes = 0, ilops = 0, pwr = 0, errs = 0, bgs = 0, n;
    wake_src_t fsrc[6] = '{SRC_RESET, SRC_LVD, SRC_ADC, SRC_IRQ, SRC_KEYPAD, SRC_SERIAL};

    always #4 sys_clk = ~sys_clk;

    stop_mode_power_sequencer #(.WAKE_TICK(TICK)) stop_mode_power_sequencer_i (.sys_clk,
        .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .stopStrobe,
        .resetPin_n, .irqPin_n, .wakeReq, .bgCommand, .memStatusCmd, .powerCtl,
        .illegalOpReset, .partialWakeReset, .wakeValid, .wakeSource, .stopStatusErr,
        .enterBackground);
    wake_source_model wake_source_model_i (.sys_clk, .fire, .lag, .resetPin_n, .irqPin_n,
        .wakeReq, .bgCommand);

    task automatic cmpv(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        if (failures == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // watcher: read data stand only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (rdPend) cmpv("regRdData", expRd.pop_front(), regRdData);
        if (wakeValid === 1'b1) begin
            cmpv("wakeSource", 16'(expWake.pop_front()), 16'(wakeSource));
            wakes++;
        end
        ilops += int'(illegalOpReset === 1'b1);
        pwr   += int'(partialWakeReset === 1'b1);
        errs  += int'(stopStatusErr === 1'b1);
        bgs   += int'(enterBackground === 1'b1);
        rdPend = regRead;
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk); regWrite <= 1'b1; regAddr <= a; regWrData <= d;
        @(posedge sys_clk); regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk); regRead <= 1'b1; regAddr <= a; expRd.push_back(e);
        @(posedge sys_clk); regRead <= 1'b0;
    endtask
    // one-cycle strobes: core stop and debug memory-with-status
    task automatic enter_stop(input logic [7:0] e);
        @(posedge sys_clk); stopStrobe <= 1'b1;
        @(posedge sys_clk); stopStrobe <= 1'b0;
        #1 cmpv("powerCtl", 16'(e), 16'(powerCtl));
    endtask
    task automatic mem_cmd();
        @(posedge sys_clk); memStatusCmd <= 1'b1;
        @(posedge sys_clk); memStatusCmd <= 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic poke(input wake_src_t s);
        @(posedge sys_clk); fire <= s; lag <= 2'($urandom_range(3));
        @(posedge sys_clk); fire <= SRC_NONE;
    endtask
    // bounded wait; a wake that never comes ends the run
    task automatic wait_wake(input int m, input int bound);
        for (int i = 0; i < bound && wakes == m; i++) @(negedge sys_clk);
        if (wakes == m) begin
            failures++;
            complete_run();
        end
    endtask
    task automatic wake(input wake_src_t s, input wake_src_t e);
        int m;
        m = wakes;
        expWake.push_back(e);
        poke(s);
        wait_wake(m, 12);
    endtask
    // gating in full retention stop from the control bits
    function automatic logic [7:0] full_pc(input logic [15:0] k);
        return {1'b0, k[2], k[5] | k[2], k[2], k[2] | (k[3] & k[4]), k[6], 1'b0, 1'b1};
    endfunction

    initial begin
        #200000;
        failures++;
        complete_run();
    end

    initial begin
        void'($urandom(96));
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        #1 cmpv("powerCtl", 16'h00FD, 16'(powerCtl));
        rd(`OFS_CTRL, 16'h0000);
        rd(`OFS_STATUS, 16'h0000);
        rd(4'hF, 16'h0000);
        // stop enable clear: a stop only raises the illegal opcode reset
        c = 16'($urandom) & 16'h077E;
        wr(`OFS_CTRL, c);
        rd(`OFS_CTRL, c);
        mem_cmd();
        enter_stop(8'hFD);
        repeat (2) @(negedge sys_clk);
        cmpv("illegalOp", 16'h0001, 16'(ilops));
        cmpv("statusErr", 16'h0000, 16'(errs));
        foreach (fsrc[i]) begin
            wr(`OFS_CTRL, 16'h0001);
            enter_stop(8'h01);
            wake(fsrc[i], fsrc[i]);
            #1 cmpv("powerCtl", 16'h00FD, 16'(powerCtl));
        end
        // random settings pick the stop type and the gating
        repeat (10) begin
            c = (16'($urandom) & 16'h007E) | 16'h0001;
            part = c[1] & ~c[2] & ~(c[3] & c[4]);
            n = pwr;
            wr(`OFS_CTRL, c);
            enter_stop(part ? 8'h02 : full_pc(c));
            wake(SRC_RESET, SRC_RESET);
            if (part) begin
                #1 cmpv("powerCtl", 16'h00FF, 16'(powerCtl));
                cmpv("wakeReset", 16'(n + 1), 16'(pwr));
                rd(`OFS_STATUS, 16'h0019);
                rd(`OFS_CTRL, 16'h0000);
                wr(`OFS_STATUS, 16'h0100);
                rd(`OFS_STATUS, 16'h0010);
                #1 cmpv("powerCtl", 16'h00FD, 16'(powerCtl));
            end
        end
        // partial stop: keypad is dead, irq pin wakes
        wr(`OFS_CTRL, 16'h0003);
        enter_stop(8'h02);
        poke(SRC_KEYPAD);
        repeat (6) @(negedge sys_clk);
        cmpv("powerCtl", 16'h0002, 16'(powerCtl));
        wake(SRC_IRQ, SRC_RESET);
        wr(`OFS_STATUS, 16'h0100);
        // select zero never wakes; the choice holds against later writes
        wr(`OFS_CTRL, 16'h0001);
        enter_stop(8'h01);
        wr(`OFS_CTRL, 16'h0004);
        repeat (3 * TICK + 4) @(negedge sys_clk);
        cmpv("powerCtl", 16'h0001, 16'(powerCtl));
        wake(SRC_RESET, SRC_RESET);
        wr(`OFS_CTRL, 16'h0101);
        n = wakes;
        expWake.push_back(SRC_PERIOD);
        enter_stop(8'h01);
        wait_wake(n, 2 * TICK + 4);
        // debug kept alive: status error while stopped, background wakes
        wr(`OFS_CTRL, 16'h0007);
        enter_stop(full_pc(16'h0007));
        mem_cmd();
        cmpv("statusErr", 16'h0001, 16'(errs));
        wake(SRC_DEBUG, SRC_DEBUG);
        cmpv("background", 16'h0001, 16'(bgs));
        complete_run();
    end
endmodule // tb_top
`default_nettype wire

// ===== testbench/wake_source_model.sv
/*
  Far-side stand-in for the sequencer: reset and irq pins, wake requests
  and the debug BACKGROUND command, each shown as a one-cycle event.
  Assumes the bench holds fire for one cycle; lag sets a prompt or slow answer.
*/
`timescale 1ns/1ps
`default_nettype none
module wake_source_model
    import stop_seq_pkg::*;
(
    // clock
    input  wire logic       sys_clk,
    // command from the bench
    input  wire wake_src_t  fire,
    input  wire logic [1:0] lag,
    // toward the sequencer
    output logic            resetPin_n,
    output logic            irqPin_n,
    output wake_req_t       wakeReq,
    output logic            bgCommand
);
    wake_src_t  pend = SRC_NONE;  // event waiting out its lag
    logic [1:0] cnt  = 2'h0;      // cycles left before it shows
    logic       act;              // event on the pins this cycle

    // one event at a time; a new command replaces a pending one
    always_ff @(posedge sys_clk) begin
        if (fire != SRC_NONE) begin
            pend <= fire;
            cnt  <= lag;
        end else if (pend != SRC_NONE) begin
            if (cnt == 2'h0) pend <= SRC_NONE;
            else cnt <= cnt - 2'h1;
        end
    end

    // pins sit at their pulled-up idle level outside events
    assign act        = (pend != SRC_NONE) && (cnt == 2'h0);
    assign resetPin_n = !(act && pend == SRC_RESET);
    assign irqPin_n   = !(act && pend == SRC_IRQ);
    assign wakeReq    = '{lowvolt_detector: act && pend == SRC_LVD, adc: act && pend == SRC_ADC,
                          irq: act && pend == SRC_IRQ, keypad: act && pend == SRC_KEYPAD,
                          serial: act && pend == SRC_SERIAL};
    assign bgCommand  = act && pend == SRC_DEBUG;
endmodule // wake_source_model
`default_nettype wire
